// File: design/tdac_pkg.sv
// package of constants and types for the target abort-dma control block
package tdac_pkg;
    localparam logic [7:0] CMD_ABORT_DMA    = 8'h04;
    localparam logic [7:0] CMD_DMA_BIT_MASK = 8'h80;
    localparam logic [7:0] CMD_SEND_DATA    = 8'h22;
    localparam logic [7:0] CMD_RECV_DATA    = 8'h2A;
    localparam int         STAT_OVERRUN_BIT = 6;
    localparam int         STAT_TC_ZERO_BIT = 4;
    localparam int         SEQ_OFFSET_BIT   = 3;
    localparam logic [4:0] FIFO_FULL_FLAGS  = 5'h10;
    localparam int         QUEUE_DEPTH      = 2;
    localparam logic [7:0] CMD_RESET_VALUE  = 8'h00;
    typedef enum logic [2:0] {
        TDAC_IDLE,
        TDAC_RUN,
        TDAC_HALT,
        TDAC_DRAIN,
        TDAC_DONE
    } tdac_state_e;
endpackage

// File: design/tdac_cmdq_if.sv
// interface between the controller and its command queue
`timescale 1ns/1ps
interface tdac_cmdq_if;
    logic       push;
    logic [7:0] push_cmd;
    logic       pop;
    logic       flush;
    logic       head_valid;
    logic [7:0] head_cmd;
    logic       wait_valid;
    modport ctrl (output push, push_cmd, pop, flush, input head_valid, head_cmd, wait_valid);
    modport queue (input push, push_cmd, pop, flush, output head_valid, head_cmd, wait_valid);
endinterface

// File: design/tdac_cmd_queue.sv
// two-entry command queue with registered outputs
`timescale 1ns/1ps
module tdac_cmd_queue
(
    input  wire logic   clk_i,
    input  wire logic   resetn_i,
    tdac_cmdq_if.queue  q
);
    logic [7:0] slot_ff [tdac_pkg::QUEUE_DEPTH];
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;

    assign nxt_cnt = q.flush ? 2'h0 :
                     (cnt_ff - {1'b0, q.pop & (cnt_ff != 2'h0)}
                      + {1'b0, q.push & (cnt_ff != 2'h2)});

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            cnt_ff   <= 2'h0;
            slot_ff[0] <= tdac_pkg::CMD_RESET_VALUE;
            slot_ff[1] <= tdac_pkg::CMD_RESET_VALUE;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            if (q.pop && cnt_ff != 2'h0)
                slot_ff[0] <= slot_ff[1];
            if (q.push && !q.flush)
            begin
                if (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && q.pop))
                    slot_ff[0] <= q.push_cmd;
                else if (cnt_ff == 2'h1 || q.pop)
                    slot_ff[1] <= q.push_cmd;
            end
        end
    end

    assign q.head_valid = cnt_ff != 2'h0;
    assign q.head_cmd   = slot_ff[0];
    assign q.wait_valid = cnt_ff == 2'h2;
endmodule

// File: design/tdac_ctrl.sv
// target abort-dma control: command intake, transfer halt, abort and completion
`timescale 1ns/1ps
module tdac_ctrl
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       cmd_wr_i,
    input  wire logic [7:0] cmd_i,
    input  wire logic       sync_mode_i,
    input  wire logic       dma_queue_empty_i,
    input  wire logic [4:0] fifo_flags_i,
    input  wire logic       tc_zero_i,
    input  wire logic       offset_max_i,
    input  wire logic [4:0] offset_count_i,
    input  wire logic       scsi_req_i,
    input  wire logic       scsi_ack_i,
    input  wire logic       xfer_done_i,
    input  wire logic       ovr_clear_i,
    output logic            dma_request_o,
    output logic            xfer_active_o,
    output logic            xfer_halted_o,
    output logic            func_complete_o,
    output logic            overrun_err_o,
    output logic            abort_done_o,
    output logic [4:0]      ack_outstanding_o
);
    tdac_cmdq_if cq ();

    tdac_cmd_queue u_queue
    (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .q        (cq.queue)
    );

    tdac_pkg::tdac_state_e state_ff;
    tdac_pkg::tdac_state_e nxt_state;
    logic       is_send_ff;
    logic [4:0] ack_cnt_ff;

    function automatic logic is_dma_xfer(input logic [7:0] c);
        is_dma_xfer = ((c | tdac_pkg::CMD_DMA_BIT_MASK) ==
                       (tdac_pkg::CMD_SEND_DATA | tdac_pkg::CMD_DMA_BIT_MASK)) ||
                      ((c | tdac_pkg::CMD_DMA_BIT_MASK) ==
                       (tdac_pkg::CMD_RECV_DATA | tdac_pkg::CMD_DMA_BIT_MASK));
    endfunction

    wire        wr_abort    = cmd_wr_i && cmd_i == tdac_pkg::CMD_ABORT_DMA;
    wire        active      = state_ff == tdac_pkg::TDAC_RUN || state_ff == tdac_pkg::TDAC_HALT;
    wire        abort_take  = wr_abort && active;
    wire        head_start  = cq.head_valid && state_ff == tdac_pkg::TDAC_IDLE;
    wire        head_dma    = head_start && is_dma_xfer(cq.head_cmd) && cq.head_cmd[7];
    wire        head_is_snd = (cq.head_cmd | tdac_pkg::CMD_DMA_BIT_MASK) ==
                              (tdac_pkg::CMD_SEND_DATA | tdac_pkg::CMD_DMA_BIT_MASK);
    wire        steady_send = dma_queue_empty_i;
    wire        steady_arx  = fifo_flags_i == tdac_pkg::FIFO_FULL_FLAGS || tc_zero_i;
    wire        steady_srx  = tc_zero_i || offset_max_i;
    wire        steady      = is_send_ff ? steady_send : (sync_mode_i ? steady_srx : steady_arx);
    wire        ack_in      = scsi_ack_i && ack_cnt_ff != 5'h00;
    wire        req_out     = scsi_req_i && ack_cnt_ff != 5'h1F;
    wire [4:0]  nxt_ack     = ack_cnt_ff + {4'h0, req_out} - {4'h0, ack_in};
    wire        drain_ok    = is_send_ff ? (!sync_mode_i || offset_count_i == 5'h00)
                                         : (!sync_mode_i || nxt_ack == 5'h00);

    assign cq.push     = cmd_wr_i && !wr_abort;
    assign cq.push_cmd = cmd_i;
    assign cq.pop      = head_start || (wr_abort && cq.wait_valid);
    assign cq.flush    = state_ff == tdac_pkg::TDAC_DRAIN && drain_ok;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            tdac_pkg::TDAC_IDLE:  if (head_start) nxt_state = head_dma ? tdac_pkg::TDAC_RUN
                                                                        : tdac_pkg::TDAC_IDLE;
            tdac_pkg::TDAC_RUN:   if (abort_take) nxt_state = tdac_pkg::TDAC_DRAIN;
                                  else if (xfer_done_i) nxt_state = tdac_pkg::TDAC_DONE;
                                  else if (steady) nxt_state = tdac_pkg::TDAC_HALT;
            tdac_pkg::TDAC_HALT:  if (abort_take) nxt_state = tdac_pkg::TDAC_DRAIN;
                                  else if (xfer_done_i) nxt_state = tdac_pkg::TDAC_DONE;
            tdac_pkg::TDAC_DRAIN: if (drain_ok) nxt_state = tdac_pkg::TDAC_DONE;
            tdac_pkg::TDAC_DONE:  nxt_state = tdac_pkg::TDAC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_ff          <= tdac_pkg::TDAC_IDLE;
            is_send_ff        <= 1'b0;
            ack_cnt_ff        <= 5'h00;
            dma_request_o     <= 1'b0;
            xfer_active_o     <= 1'b0;
            xfer_halted_o     <= 1'b0;
            func_complete_o   <= 1'b0;
            overrun_err_o     <= 1'b0;
            abort_done_o      <= 1'b0;
            ack_outstanding_o <= 5'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            if (head_dma)
                is_send_ff <= head_is_snd;
            ack_cnt_ff        <= sync_mode_i ? nxt_ack : 5'h00;
            ack_outstanding_o <= sync_mode_i ? nxt_ack : 5'h00;
            dma_request_o     <= nxt_state == tdac_pkg::TDAC_RUN ||
                                 nxt_state == tdac_pkg::TDAC_HALT;
            xfer_active_o     <= nxt_state != tdac_pkg::TDAC_IDLE &&
                                 nxt_state != tdac_pkg::TDAC_DONE;
            xfer_halted_o     <= nxt_state == tdac_pkg::TDAC_HALT;
            func_complete_o   <= nxt_state == tdac_pkg::TDAC_DONE;
            abort_done_o      <= state_ff == tdac_pkg::TDAC_DRAIN && drain_ok;
            if (wr_abort && cq.wait_valid)
                overrun_err_o <= 1'b1;
            else if (ovr_clear_i)
                overrun_err_o <= 1'b0;
        end
    end
endmodule

// File: tb/tdac_initiator_model.sv
// initiator model: answers each req pulse with an ack lag_i+1 cycles later
`timescale 1ns/1ps
module tdac_initiator_model
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       req_i,
    input  wire logic [3:0] lag_i,
    output logic            ack_o
);
    logic [15:0] pipe_ff;
    assign ack_o = pipe_ff[lag_i];
    always_ff @(posedge clk_i)
    begin
        pipe_ff <= resetn_i ? {pipe_ff[14:0], req_i} : 16'h0000;
    end
endmodule

// File: tb/tdac_ctrl_properties.sv
// port assertions for the abort-dma control block
`timescale 1ns/1ps
module tdac_ctrl_properties
(
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       cmd_wr_i,
    input wire logic [7:0] cmd_i,
    input wire logic       sync_mode_i,
    input wire logic [4:0] offset_count_i,
    input wire logic       scsi_req_i,
    input wire logic       scsi_ack_i,
    input wire logic       dma_request_o,
    input wire logic       xfer_active_o,
    input wire logic       xfer_halted_o,
    input wire logic       func_complete_o,
    input wire logic       abort_done_o,
    input wire logic [4:0] ack_outstanding_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire abort_cmd = cmd_wr_i && cmd_i == 8'h04;
    wire ack_only  = sync_mode_i && xfer_active_o && scsi_ack_i && !scsi_req_i;
    a_abort_drops_req: assert property (abort_cmd && xfer_active_o |-> ##[1:2] !dma_request_o)
        else $error("dma request kept after abort");
    a_async_done_soon: assert property (abort_cmd && xfer_active_o && !sync_mode_i |-> ##[1:3] abort_done_o)
        else $error("async abort not finished");
    a_done_with_complete: assert property (abort_done_o |-> func_complete_o)
        else $error("abort end without command completion");
    a_halt_keeps_req: assert property (xfer_halted_o |-> dma_request_o)
        else $error("halt without dma request");
    a_req_stays_low: assert property (abort_done_o && !cmd_wr_i |=> !dma_request_o [*2])
        else $error("dma request back after abort");
    a_dma_code_ignored: assert property (cmd_wr_i && cmd_i == 8'h84 && xfer_halted_o |=> dma_request_o)
        else $error("dma form of abort accepted");
    a_ack_count_down: assert property (ack_only && ack_outstanding_o != 5'h00 |=> ack_outstanding_o == $past(ack_outstanding_o) - 5'h01)
        else $error("ack count not decremented");
    a_sync_drain_wait: assert property (sync_mode_i && xfer_active_o && !dma_request_o && offset_count_i != 5'h00 && ack_outstanding_o != 5'h00 |=> !abort_done_o)
        else $error("sync abort finished early");
    c_halt: cover property ($rose(xfer_halted_o));
    c_async_abort: cover property (abort_cmd && !sync_mode_i && xfer_halted_o);
    c_sync_end: cover property (abort_done_o && sync_mode_i);
endmodule
bind tdac_ctrl tdac_ctrl_properties tdac_ctrl_properties_i (.*);

// File: tb/tb.sv
// self-checking bench for the abort-dma control block
`timescale 1ns/1ps
module tb;
    logic       clk_i = 0, resetn_i = 0, cmd_wr_i = 0, sync_mode_i = 0, dma_queue_empty_i = 0;
    logic       tc_zero_i = 0, offset_max_i = 0, scsi_req_i = 0, ovr_clear_i = 0, xfer_done_i = 0;
    logic [7:0] cmd_i = 8'h00;
    logic [4:0] fifo_flags_i = 5'h00, offset_count_i = 5'h00, ack_outstanding_o;
    logic [3:0] lag = 4'h1;
    logic       scsi_ack_i, dma_request_o, xfer_active_o, xfer_halted_o;
    logic       func_complete_o, overrun_err_o, abort_done_o;
    int         miscompares = 0, checks_done = 0;
    tdac_ctrl tdac_ctrl_i (.*);
    tdac_initiator_model tdac_initiator_model_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .req_i(scsi_req_i), .lag_i(lag), .ack_o(scsi_ack_i));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic final_report();
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input logic [7:0] code);
        cmd_i = code;
        cmd_wr_i = 1;
        tick(1);
        cmd_wr_i = 0;
    endtask
    task automatic start(input logic [7:0] code);
        cmd(code);
        tick(3);
        chk("dma_request", dma_request_o, 8'h01);
    endtask
    task automatic wait_done(input int n);
        for (int i = 0; i < n && abort_done_o !== 1'b1; i++) tick(1);
        if (abort_done_o !== 1'b1)
        begin
            miscompares++;
            final_report();
        end
        chk("func_complete", func_complete_o, 8'h01);
    endtask
    task automatic t_async_send();
        start(8'hA2);
        dma_queue_empty_i = 1;
        tick(2);
        chk("halted", xfer_halted_o, 8'h01);
        cmd(8'h84);
        tick(1);
        cmd(8'hA2);
        tick(1);
        chk("dma_request", dma_request_o, 8'h01);
        cmd(8'h04);
        tick(1);
        chk("dma_request", dma_request_o, 8'h00);
        wait_done(3);
        chk("overrun", overrun_err_o, 8'h01);
        tick(3);
        chk("dma_request", dma_request_o, 8'h00);
        dma_queue_empty_i = 0;
    endtask
    task automatic t_async_recv();
        ovr_clear_i = 1;
        tick(1);
        ovr_clear_i = 0;
        cmd(8'h04);
        tick(3);
        chk("func_complete", func_complete_o, 8'h00);
        start(8'hAA);
        fifo_flags_i = 5'h10;
        tick(2);
        chk("halted", xfer_halted_o, 8'h01);
        cmd(8'h04);
        wait_done(4);
        chk("overrun", overrun_err_o, 8'h00);
        fifo_flags_i = 5'h00;
    endtask
    task automatic t_sync_send();
        sync_mode_i = 1;
        start(8'hA2);
        offset_count_i = 5'h03;
        dma_queue_empty_i = 1;
        tick(2);
        cmd(8'h04);
        tick(4);
        chk("active", xfer_active_o, 8'h01);
        offset_count_i = 5'h00;
        wait_done(3);
        dma_queue_empty_i = 0;
    endtask
    task automatic t_sync_recv();
        lag = 4'hC;
        start(8'hAA);
        offset_count_i = 5'h02;
        scsi_req_i = 1;
        tick(3);
        scsi_req_i = 0;
        offset_max_i = 1;
        tick(1);
        chk("ack_outstanding", {3'h0, ack_outstanding_o}, 8'h03);
        chk("halted", xfer_halted_o, 8'h01);
        cmd(8'h04);
        tick(3);
        chk("active", xfer_active_o, 8'h01);
        wait_done(12);
        chk("ack_outstanding", {3'h0, ack_outstanding_o}, 8'h00);
    endtask
    initial
    begin
        tick(10);
        resetn_i = 1;
        t_async_send();
        t_async_recv();
        t_sync_send();
        t_sync_recv();
        final_report();
    end
endmodule
